// ---- core/mcss_pkg.sv ----
package mcss_pkg;
  // field layout of the velocity constant code
  localparam int KT_CODE_W = 7;
  localparam int KT_EXP_W = 3;
  localparam int KT_MANT_W = 4;
  localparam int KT_EXP_LSB = 4;
  localparam int KT_MANT_LSB = 0;
  localparam int KT_VAL_W = 11;                 // 15 << 7 = 1920 fits in 11 bits
  localparam int KT_MANT_MIN_SHIFTED = 8;       // mantissa floor once exponent is non-zero
  // register offsets (word index on the plain port)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_KT = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_KTVAL = 4'h3;
  // control bit positions
  localparam int CTRL_SPIN_CHECK = 0;
  localparam int CTRL_RESYNC = 1;
  localparam int CTRL_POSDET = 2;
  localparam int CTRL_BRAKE = 3;
  localparam int CTRL_START = 4;
  // reset values
  localparam logic [6:0] KT_RESET = 7'h00;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  // time the align or position step is held, and the brake time
  localparam int ALIGN_TIME_US = 100;
  localparam int BRAKE_TIME_US = 100;
  localparam int CLK_MHZ = 25;
  localparam int ALIGN_CYCLES = ALIGN_TIME_US * CLK_MHZ;
  localparam int BRAKE_CYCLES = BRAKE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    MCSS_STILL,
    MCSS_FWD,
    MCSS_REV
  } mcss_motion_t;

  typedef enum logic [2:0] {
    MCSS_PATH_NONE,
    MCSS_PATH_POSDET,
    MCSS_PATH_ALIGN,
    MCSS_PATH_RESYNC,
    MCSS_PATH_WAIT,
    MCSS_PATH_BRAKE
  } mcss_path_t;
endpackage : mcss_pkg

// ---- core/mcss_kt_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcss_kt_decode (
  input  wire logic [mcss_pkg::KT_CODE_W-1:0] code,   // packed exponent and mantissa
  output logic      [mcss_pkg::KT_VAL_W-1:0]  value,  // decoded digital constant
  output logic                                valid   // code is a legal encoding
);
  import mcss_pkg::*;

  logic [KT_EXP_W-1:0]  exponent;
  logic [KT_MANT_W-1:0] mantissa;

  // split the code and shift the mantissa by the exponent
  always_comb begin
    exponent = code[KT_EXP_LSB +: KT_EXP_W];                         // [R02]
    mantissa = code[KT_MANT_LSB +: KT_MANT_W];                       // [R02]
    value = KT_VAL_W'({7'h00, mantissa} << exponent);                // [R04] [R05] [R06]
    // a non-zero exponent needs a normalised mantissa, else the code is ambiguous
    valid = (exponent == 3'h0) || (mantissa >= 4'(KT_MANT_MIN_SHIFTED)); // [R07]
  end
endmodule : mcss_kt_decode
`default_nettype wire

// ---- core/mcss_core.sv ----
// Operation
// R01: decoded constant is the back-EMF to electrical-speed ratio for the motor model
// R02: constant is a 7-bit code, 3-bit exponent above a 4-bit mantissa
// R03: host scales the measured constant by 1090 before encoding
// R04: decoded value is mantissa shifted left by exponent
// R05: code 0x7f decodes to 1920, the largest constant
// R06: code 0x01 decodes to 1, the smallest non-zero constant
// R07: codes with non-zero exponent must carry mantissa 8 to 15
// R08: at start-up classify motor as still, forward or reverse, pick a path
// R09: still motor starts by position detection or align-and-go
// R10: position detection reads rotor angle from inductance variation
// R11: align-and-go drives one chosen phase to pull the rotor in line
// R12: when enabled, forward-spinning motor resyncs straight into closed loop
// R13: with spin check off the motor is treated as still
// R14: reverse motor without reverse drive waits or brakes, then starts as still
// R15: code is host-written and its decoded value used only after a full write
`timescale 1ns/1ps
`default_nettype none
module mcss_core #(
  parameter int ALIGN_CNT = mcss_pkg::ALIGN_CYCLES,   // align / detection hold in cycles
  parameter int BRAKE_CNT = mcss_pkg::BRAKE_CYCLES    // brake hold in cycles
) (
  input  wire logic                        clock,        // 25 MHz core clock
  input  wire logic                        sys_rst,      // async reset, active high
  input  wire logic [mcss_pkg::ADDR_W-1:0] addr,         // register index
  input  wire logic [31:0]                 wdata,        // write data
  input  wire logic                        wr,           // write strobe
  input  wire logic                        rd,           // read strobe
  output logic      [31:0]                 rdata,        // read data, cycle after rd
  input  wire logic                        motion_valid, // spin measurement ready (pin)
  input  wire logic                        motion_fwd,   // motor turning forward (pin)
  input  wire logic                        motion_moving,// motor above still threshold (pin)
  output logic      [mcss_pkg::KT_VAL_W-1:0] kt_value,   // decoded constant for the model
  output logic                             sense_inductance, // position detection pulses
  output logic                             align_drive,  // drive the align phase
  output logic                             brake_on,     // all low-side on
  output logic                             closed_loop   // closed-loop drive active
);
  import mcss_pkg::*;

  typedef enum logic [2:0] {
    MCSS_IDLE,
    MCSS_SENSE,
    MCSS_STOP_WAIT,
    MCSS_BRAKING,
    MCSS_POS,
    MCSS_ALIGN,
    MCSS_RUN
  } mcss_state_t;

  typedef struct packed {
    logic [KT_CODE_W-1:0] kt_code;
    logic [KT_VAL_W-1:0]  kt_live;
    logic [7:0]           ctrl;
    mcss_state_t          state;
    mcss_motion_t         motion;
    mcss_path_t           path;
    logic [CNT_W-1:0]     cnt;
    logic [31:0]          rdata;
    logic [1:0]           valid_s;
    logic [1:0]           fwd_s;
    logic [1:0]           moving_s;
  } mcss_st_t;

  mcss_st_t st;
  mcss_st_t next_st;

  logic [KT_VAL_W-1:0] dec_value;
  logic                dec_valid;

  initial begin
    if (ALIGN_CNT < 1 || ALIGN_CNT >= (1 << CNT_W)) $error("ALIGN_CNT out of range");
    if (BRAKE_CNT < 1 || BRAKE_CNT >= (1 << CNT_W)) $error("BRAKE_CNT out of range");
  end

  // combinational decode of the stored code only
  mcss_kt_decode u_dec (
    .code  (st.kt_code),
    .value (dec_value),
    .valid (dec_valid)
  );

  // next-state logic
  always_comb begin
    next_st = st;
    // pin inputs pass two flops before use
    next_st.valid_s = {st.valid_s[0], motion_valid};
    next_st.fwd_s = {st.fwd_s[0], motion_fwd};
    next_st.moving_s = {st.moving_s[0], motion_moving};
    // write path: the code lands whole in one strobe
    if (wr) begin
      unique case (addr)
        REG_KT: next_st.kt_code = wdata[KT_CODE_W-1:0];              // [R15] [R02]
        REG_CTRL: next_st.ctrl = wdata[7:0];
        default: ;
      endcase
    end
    // decoded value taken only from a completed write, so the model never sees a half code
    if (dec_valid) next_st.kt_live = dec_value;                      // [R15] [R07] [R01]
    // read path, unmapped reads return zero
    next_st.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        REG_KT: next_st.rdata = {25'h0, st.kt_code};
        REG_CTRL: next_st.rdata = {24'h0, st.ctrl};
        REG_STAT: next_st.rdata = {23'h0, st.path, st.motion, 1'b0, st.state};
        REG_KTVAL: next_st.rdata = {20'h0, dec_valid, st.kt_live};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // start bit self-clears once taken
    if (st.state == MCSS_IDLE && st.ctrl[CTRL_START] && !(wr && addr == REG_CTRL)) begin
      next_st.ctrl[CTRL_START] = 1'b0;
    end
    if (st.cnt != '0) next_st.cnt = st.cnt - 1'b1;
    unique case (st.state)
      MCSS_IDLE: begin
        if (st.ctrl[CTRL_START]) begin
          if (st.ctrl[CTRL_SPIN_CHECK]) begin
            next_st.state = MCSS_SENSE;                              // [R08]
          end else begin
            // skipping the check means assuming a still rotor
            next_st.motion = MCSS_STILL;                             // [R13]
            next_st.state = st.ctrl[CTRL_POSDET] ? MCSS_POS : MCSS_ALIGN; // [R09]
            next_st.path = st.ctrl[CTRL_POSDET] ? MCSS_PATH_POSDET : MCSS_PATH_ALIGN;
            next_st.cnt = CNT_W'(ALIGN_CNT);
          end
        end
      end
      MCSS_SENSE: begin
        if (st.valid_s[1]) begin
          if (!st.moving_s[1]) begin
            next_st.motion = MCSS_STILL;                             // [R08]
            next_st.state = st.ctrl[CTRL_POSDET] ? MCSS_POS : MCSS_ALIGN; // [R09]
            next_st.path = st.ctrl[CTRL_POSDET] ? MCSS_PATH_POSDET : MCSS_PATH_ALIGN;
            next_st.cnt = CNT_W'(ALIGN_CNT);
          end else if (st.fwd_s[1]) begin
            next_st.motion = MCSS_FWD;                               // [R08]
            if (st.ctrl[CTRL_RESYNC]) begin
              next_st.state = MCSS_RUN;                              // [R12]
              next_st.path = MCSS_PATH_RESYNC;
            end else begin
              // no resync: let it coast down and restart as still
              next_st.state = MCSS_STOP_WAIT;
              next_st.path = MCSS_PATH_WAIT;
            end
          end else begin
            next_st.motion = MCSS_REV;                               // [R08]
            if (st.ctrl[CTRL_BRAKE]) begin
              next_st.state = MCSS_BRAKING;                          // [R14]
              next_st.path = MCSS_PATH_BRAKE;
              next_st.cnt = CNT_W'(BRAKE_CNT);
            end else begin
              next_st.state = MCSS_STOP_WAIT;                        // [R14]
              next_st.path = MCSS_PATH_WAIT;
            end
          end
        end
      end
      MCSS_STOP_WAIT: begin
        // wait for the still verdict, then proceed as for a stationary motor
        if (st.valid_s[1] && !st.moving_s[1]) begin
          next_st.state = st.ctrl[CTRL_POSDET] ? MCSS_POS : MCSS_ALIGN; // [R14]
          next_st.cnt = CNT_W'(ALIGN_CNT);
        end
      end
      MCSS_BRAKING: begin
        if (st.cnt == CNT_W'(1)) begin
          next_st.state = st.ctrl[CTRL_POSDET] ? MCSS_POS : MCSS_ALIGN; // [R14]
          next_st.cnt = CNT_W'(ALIGN_CNT);
        end
      end
      MCSS_POS, MCSS_ALIGN: begin
        if (st.cnt == CNT_W'(1)) next_st.state = MCSS_RUN;
      end
      MCSS_RUN: begin
        // software stop is out of scope; hold here unless start is set again with spin check off, which returns to idle
        if (!st.ctrl[CTRL_SPIN_CHECK] && st.ctrl[CTRL_START]) next_st.state = MCSS_IDLE;
      end
      default: next_st.state = MCSS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{kt_code: KT_RESET, kt_live: '0, ctrl: CTRL_RESET, state: MCSS_IDLE,
              motion: MCSS_STILL, path: MCSS_PATH_NONE, cnt: '0, rdata: '0,
              valid_s: '0, fwd_s: '0, moving_s: '0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  always_comb begin
    rdata = st.rdata;
    kt_value = st.kt_live;                                           // [R01]
    sense_inductance = (st.state == MCSS_POS);                       // [R10]
    align_drive = (st.state == MCSS_ALIGN);                          // [R11]
    brake_on = (st.state == MCSS_BRAKING);                           // [R14]
    closed_loop = (st.state == MCSS_RUN);                            // [R12]
  end
endmodule : mcss_core
`default_nettype wire

// ---- tb/mcss_core_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcss_core_chk #(
  parameter int ALIGN_CNT = 4, // align hold
  parameter int BRAKE_CNT = 4  // brake hold
) (
  input wire logic                          clock,            // clock
  input wire logic                          sys_rst,          // reset
  input wire logic [mcss_pkg::ADDR_W-1:0]   addr,             // index
  input wire logic [31:0]                   wdata,            // wr data
  input wire logic                          wr,               // write
  input wire logic                          rd,               // read
  input wire logic [31:0]                   rdata,            // rd data
  input wire logic [mcss_pkg::KT_VAL_W-1:0] kt_value,         // constant
  input wire logic                          sense_inductance, // detect
  input wire logic                          align_drive,      // align
  input wire logic                          brake_on,         // brake
  input wire logic                          closed_loop       // run
);
  import mcss_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // legal codes decode as mantissa shifted by exponent
  property kt_ok;
    logic [6:0] c;
    (wr && addr == REG_KT && (wdata[6:4] == 3'h0 || wdata[3]), c = wdata[6:0])
      |-> ##2 kt_value == (11'(c[3:0]) << c[6:4]);
  endproperty
  // an illegal code must not disturb the constant in use
  property kt_hold;
    logic [10:0] v;
    (wr && addr == REG_KT && wdata[6:4] != 3'h0 && !wdata[3], v = kt_value)
      |-> ##2 kt_value == v;
  endproperty
  kt_legal_a: assert property (kt_ok)
    else $error("kt decode wrong");
  kt_illegal_a: assert property (kt_hold)
    else $error("illegal kt used");
  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata not zero");
  unmapped_rd_a: assert property (rd && addr > REG_KTVAL |=> rdata == 32'h0)
    else $error("unmapped read");
  ktval_rd_a: assert property (rd && addr == REG_KTVAL |=> rdata[10:0] == $past(kt_value))
    else $error("ktval read wrong");
  drive_excl_a: assert property ($onehot0({sense_inductance, align_drive, brake_on, closed_loop}))
    else $error("drives overlap");
  brake_hold_a: assert property ($rose(brake_on) |-> brake_on[*2])
    else $error("brake too short");
  posdet_go_a: assert property (wr && addr == REG_CTRL && wdata[4] && !wdata[0] && wdata[2]
    |-> ##[1:6] sense_inductance)
    else $error("no detection");
  align_go_a: assert property (wr && addr == REG_CTRL && wdata[4] && !wdata[0] && !wdata[2]
    |-> ##[1:6] align_drive)
    else $error("no align");
  cover property ($rose(closed_loop));
  cover property ($rose(brake_on));
  cover property (rd && addr == REG_KTVAL);
endmodule : mcss_core_chk
bind mcss_core mcss_core_chk #(.ALIGN_CNT(ALIGN_CNT), .BRAKE_CNT(BRAKE_CNT)) i_chk (
  .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .kt_value(kt_value), .sense_inductance(sense_inductance),
  .align_drive(align_drive), .brake_on(brake_on), .closed_loop(closed_loop));
`default_nettype wire

// ---- tb/mcss_motor.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcss_motor (
  input  wire logic                   clock,         // clock
  input  wire mcss_pkg::mcss_motion_t spin,          // motion to load
  input  wire logic                   load,          // take spin
  input  wire logic                   brake_on,      // brake from driver
  output logic                        motion_valid,  // measure ready
  output logic                        motion_fwd,    // forward
  output logic                        motion_moving  // turning
);
  import mcss_pkg::*;
  mcss_motion_t m = MCSS_STILL;
  logic [7:0]   coast = 8'h00;
  // a free rotor coasts to rest in 64 cycles; the brake stops it at once
  always @(posedge clock) begin
    coast <= load ? 8'h40 : coast - 8'(coast != 8'h00);
    if (load)
      m <= spin;
    else if (brake_on || coast == 8'h01)
      m <= MCSS_STILL;
  end
  assign motion_valid  = 1'b1;
  assign motion_fwd    = (m == MCSS_FWD);
  assign motion_moving = (m != MCSS_STILL);
endmodule : mcss_motor
`default_nettype wire

// ---- tb/mcss_core_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcss_core_tb_top;
  import mcss_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, load = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, seen;
  logic [KT_VAL_W-1:0] kt_value;
  logic mv, mf, mm, sense, align, brake, run;
  logic [3:0] drv;
  mcss_motion_t spin = MCSS_STILL;
  int n_fail = 0, checks_done = 0, n;
  // codes are already host-scaled integers; mantissa shifted by exponent
  // last code is illegal, so the previous constant stays with valid low
  logic [6:0] codes [5] = '{7'h7f, 7'h01, 7'h18, 7'h4a, 7'h21};
  logic [11:0] kvals [5] = '{12'hf80, 12'h801, 12'h810, 12'h8a0, 12'h0a0};
  logic [7:0] ctrls [5] = '{8'h14, 8'h10, 8'h13, 8'h19, 8'h15};
  mcss_motion_t moves [5] = '{MCSS_STILL, MCSS_STILL, MCSS_FWD, MCSS_REV, MCSS_REV};
  logic [2:0] paths [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
  logic [3:0] want [5] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'h1};
  assign drv = {sense, align, brake, run};
  mcss_core #(.ALIGN_CNT(4), .BRAKE_CNT(4)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .motion_valid(mv), .motion_fwd(mf), .motion_moving(mm),
    .kt_value(kt_value), .sense_inductance(sense), .align_drive(align),
    .brake_on(brake), .closed_loop(run));
  mcss_motor i_motor (.clock(clock), .spin(spin), .load(load), .brake_on(brake),
    .motion_valid(mv), .motion_fwd(mf), .motion_moving(mm));
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  // read data only stand in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    seen = rdata;
  endtask : rd_reg
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : do_reset
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    do_reset;
    rd_reg(REG_CTRL);
    chk(seen, 32'h1, "ctrl reset");
    foreach (codes[i]) begin
      wr_reg(REG_KT, {25'h0, codes[i]});
      rd_reg(REG_KTVAL);
      chk(seen, {20'h0, kvals[i]}, "kt decode");
      rd_reg(REG_KT);
      chk(seen, {25'h0, codes[i]}, "kt code");
    end
    wr_reg(4'h9, 32'h7f);
    rd_reg(4'h9);
    chk(seen, 32'h0, "unmapped");
    rd_reg(REG_KT);
    chk(seen, 32'h21, "kt kept");
    // each start case begins from a fresh reset with the rotor preset
    foreach (ctrls[i]) begin
      do_reset;
      spin <= moves[i];
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
      repeat (4) @(posedge clock);
      wr_reg(REG_CTRL, {24'h0, ctrls[i]});
      for (n = 0; (drv & want[i]) == 4'h0 && n < 300; n++) @(negedge clock);
      chk({28'h0, drv & want[i]}, {28'h0, want[i]}, "start drive");
      rd_reg(REG_STAT);
      chk({29'h0, seen[8:6]}, {29'h0, paths[i]}, "start path");
      for (n = 0; run !== 1'b1 && n < 300; n++) @(negedge clock);
      chk({31'h0, run}, 32'h1, "closed loop");
    end
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    test_done;
  end
endmodule : mcss_core_tb_top
`default_nettype wire
